// ### src/bac_regs.vh
// Register offsets, field positions and reset values for the breakpoint comparators
`ifndef BAC_REGS_VH
`define BAC_REGS_VH

// Word byte addresses on the Avalon-MM slave
`define BAC_OFF_CTRL_ONE   4'h0
`define BAC_OFF_CTRL_TWO   4'h4
`define BAC_OFF_CTRL_MASK  4'h8
`define BAC_OFF_A_EXT      4'hC
`define BAC_ADDR_W         4

// Second register bank, selected by the upper address bit
`define BAC_OFF_A_CMP      5'h10
`define BAC_OFF_B_EXT      5'h14
`define BAC_OFF_B_CMP      5'h18
`define BAC_OFF_STATUS     5'h1C

// Field positions
`define BAC_BIT_DBG_EN     7
`define BAC_BIT_FULL       6
`define BAC_BIT_BKP_EN     7
`define BAC_BIT_A_HMASK    7
`define BAC_BIT_A_LMASK    6
`define BAC_BIT_B_HMASK    5
`define BAC_BIT_B_LMASK    4
`define BAC_PAGE_TYPE_SELECTOR_LO      6

// Reset values
`define BAC_RST_BYTE       8'h00
`define BAC_RST_WORD       16'h0000

// Page type selector codes after bit 7 is dropped
`define BAC_PG_NONE        1'b0
`define BAC_PG_PROGRAM     1'b1

`endif

// ### src/bac_match.v
// One address/data comparator lane with byte masking and page compare
`timescale 1ns/1ns
`default_nettype none
`include "bac_regs.vh"

module bac_match (
  // Configuration
  input wire bkp_mode,
  input wire dbg_mode,
  input wire data_cmp,
  input wire high_mask,
  input wire low_mask,
  input wire [7:0] ext_reg,
  input wire [15:0] cmp_reg,
  // Core buses
  input wire [15:0] addr,
  input wire [21:14] xaddr,
  input wire flash_access,
  input wire [15:0] data,
  // Result
  output reg hit
);

  reg pg_sel;
  reg hi_ok;
  reg lo_ok;
  reg ext_ok;

  always @* begin
    pg_sel = ext_reg[`BAC_PAGE_TYPE_SELECTOR_LO];
    hi_ok = 1'b1;
    lo_ok = 1'b1;
    ext_ok = 1'b1;
    if (data_cmp) begin
      // Data compare: extended bits unused
      case ({high_mask, low_mask})
        2'b00: begin
          hi_ok = (cmp_reg[15:8] == data[15:8]);
          lo_ok = (cmp_reg[7:0] == data[7:0]);
        end
        2'b01: hi_ok = (cmp_reg[15:8] == data[15:8]);
        2'b10: lo_ok = (cmp_reg[7:0] == data[7:0]);
        default: ; // No data compare
      endcase
    end else begin
      if (bkp_mode && flash_access) begin
        // Page selector ignored here
        ext_ok = (ext_reg[5:0] == xaddr[19:14]);
        hi_ok = (cmp_reg[13:8] == addr[13:8]);
      end else if (dbg_mode && pg_sel == `BAC_PG_PROGRAM) begin
        ext_ok = (ext_reg[5:0] == xaddr[21:16]);
        hi_ok = (cmp_reg[15:8] == {xaddr[15:14], addr[13:8]});
      end else begin
        hi_ok = (cmp_reg[15:8] == addr[15:8]);
      end
      lo_ok = (cmp_reg[7:0] == addr[7:0]);
      // High mask alone is forced off
      if (low_mask) begin
        lo_ok = 1'b1;
        if (high_mask)
          hi_ok = 1'b1;
      end
    end
    hit = (bkp_mode || dbg_mode) && ext_ok && hi_ok && lo_ok;
  end

endmodule // bac_match

`default_nettype wire

// ### src/bac_top.v
// Breakpoint comparators A and B with Avalon-MM register slave
// Operation
// - Low/high mask bits select full, 256, 16K ranges
// - Full mode B masks select data bytes compared
// - Full mode ignores comparator B extended bits
// - Extended bits 7:6 select page type
// - Selector bit 7 ignored, 10/11 act as 00/01
// - Breakpoint mode compares page on flash accesses
// - Debug mode selector 01 compares extended address
// - Compare value bits give required address levels
// - Breakpoint enable overrides debug enable
// - Secure state blocks trace/debug mode
// - High mask alone is ignored for address compares; in full mode data compare it keeps only the low byte
// - Full mode comparator B watches data bus
`timescale 1ns/1ns
`default_nettype none
`include "bac_regs.vh"

module bac_top (
  // Clock and reset
  input wire CORE_CLK,
  input wire RST,
  // Avalon-MM slave
  input wire [4:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output reg AVS_WAITREQUEST,
  // Core buses, same clock domain
  input wire [15:0] CORE_ADDRESS_BUS,
  input wire [21:14] EXTENDED_ADDRESS_BUS,
  input wire FLASH_ACCESS,
  input wire [15:0] CORE_DATA_BUS,
  // Chip security, from a pin domain
  input wire SECURE_STATE,
  // Results
  output reg MATCH_A,
  output reg MATCH_B,
  output reg BREAKPOINT_MODE,
  output reg TRACE_DEBUG_MODE
);

  // Register file, next values merged from the bus
  reg [7:0] debug_control_one_q;
  reg [7:0] debug_control_one_d;
  reg [7:0] debug_control_two_q;
  reg [7:0] debug_control_two_d;
  reg [7:0] mask_ctrl_q;
  reg [7:0] mask_ctrl_d;
  reg [7:0] comp_a_extended_page_q;
  reg [7:0] comp_a_extended_page_d;
  reg [15:0] comp_a_compare_value_q;
  reg [15:0] comp_a_compare_value_d;
  reg [7:0] comp_b_extended_page_q;
  reg [7:0] comp_b_extended_page_d;
  reg [15:0] comp_b_compare_value_q;
  reg [15:0] comp_b_compare_value_d;
  // Security pin synchroniser
  reg sec_meta_q;
  reg sec_sync_q;
  // Bus handshake
  reg ack_q;
  reg ack_d;
  reg wait_d;
  reg [31:0] rdata_d;
  wire req;
  wire rd_fire;
  wire wr_fire;
  // Comparator results and modes
  wire bkp_on;
  wire dbg_on;
  wire full_mode;
  wire hit_a;
  wire hit_b;
  wire [4:0] status;

  // Merge a byte lane into a register byte
  function [7:0] lane;
    input [7:0] old;
    input [7:0] nw;
    input en;
    begin
      lane = en ? nw : old;
    end
  endfunction

  // Word address decode, shared by the read and write paths
  function reg_hit;
    input [4:0] adr;
    input [4:0] off;
    begin
      reg_hit = (adr == off);
    end
  endfunction

  // Pad a byte register onto the read bus
  function [31:0] byte_word;
    input [7:0] val;
    begin
      byte_word = {24'h00_0000, val};
    end
  endfunction

  // Pad a compare register onto the read bus
  function [31:0] half_word;
    input [15:0] val;
    begin
      half_word = {16'h0000, val};
    end
  endfunction

  // Security pin crosses in from outside
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sec_meta_q <= 1'b1;
      sec_sync_q <= 1'b1;
    end else begin
      sec_meta_q <= SECURE_STATE;
      sec_sync_q <= sec_meta_q;
    end
  end

  assign bkp_on = debug_control_two_q[`BAC_BIT_BKP_EN];
  // Secure start-up until synchronised keeps debug off
  assign dbg_on = debug_control_one_q[`BAC_BIT_DBG_EN] && !bkp_on && !sec_sync_q;
  assign full_mode = bkp_on && debug_control_two_q[`BAC_BIT_FULL];
  assign status = {sec_sync_q, dbg_on, bkp_on, hit_b, hit_a};

  // One wait cycle per access; a write lands only on the edge that ends the wait
  assign req = AVS_READ || AVS_WRITE;
  assign rd_fire = AVS_READ && !ack_q;
  assign wr_fire = AVS_WRITE && ack_q;

  // Read data is fetched on the first edge so it stands when the wait ends
  always @* begin
    ack_d = req && !ack_q;
    wait_d = !(req && !ack_q);
    rdata_d = AVS_READDATA;
    if (rd_fire) begin
      if (reg_hit(AVS_ADDRESS, {1'b0, `BAC_OFF_CTRL_ONE})) begin
        rdata_d = byte_word(debug_control_one_q);
      end else if (reg_hit(AVS_ADDRESS, {1'b0, `BAC_OFF_CTRL_TWO})) begin
        rdata_d = byte_word(debug_control_two_q);
      end else if (reg_hit(AVS_ADDRESS, {1'b0, `BAC_OFF_CTRL_MASK})) begin
        rdata_d = byte_word(mask_ctrl_q);
      end else if (reg_hit(AVS_ADDRESS, {1'b0, `BAC_OFF_A_EXT})) begin
        rdata_d = byte_word(comp_a_extended_page_q);
      end else if (reg_hit(AVS_ADDRESS, `BAC_OFF_A_CMP)) begin
        rdata_d = half_word(comp_a_compare_value_q);
      end else if (reg_hit(AVS_ADDRESS, `BAC_OFF_B_EXT)) begin
        rdata_d = byte_word(comp_b_extended_page_q);
      end else if (reg_hit(AVS_ADDRESS, `BAC_OFF_B_CMP)) begin
        rdata_d = half_word(comp_b_compare_value_q);
      end else if (reg_hit(AVS_ADDRESS, `BAC_OFF_STATUS)) begin
        rdata_d = {27'h000_0000, status};
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end
  end

  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ack_q <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      AVS_WAITREQUEST <= wait_d;
      AVS_READDATA <= rdata_d;
    end
  end

  // Write path: byte lanes merge into the addressed register
  always @* begin
    debug_control_one_d = debug_control_one_q;
    debug_control_two_d = debug_control_two_q;
    mask_ctrl_d = mask_ctrl_q;
    comp_a_extended_page_d = comp_a_extended_page_q;
    comp_a_compare_value_d = comp_a_compare_value_q;
    comp_b_extended_page_d = comp_b_extended_page_q;
    comp_b_compare_value_d = comp_b_compare_value_q;
    if (wr_fire) begin
      if (reg_hit(AVS_ADDRESS, {1'b0, `BAC_OFF_CTRL_ONE})) begin
        debug_control_one_d = lane(debug_control_one_q, AVS_WRITEDATA[7:0], AVS_BYTEENABLE[0]);
      end
      if (reg_hit(AVS_ADDRESS, {1'b0, `BAC_OFF_CTRL_TWO})) begin
        debug_control_two_d = lane(debug_control_two_q, AVS_WRITEDATA[7:0], AVS_BYTEENABLE[0]);
      end
      if (reg_hit(AVS_ADDRESS, {1'b0, `BAC_OFF_CTRL_MASK})) begin
        mask_ctrl_d = lane(mask_ctrl_q, AVS_WRITEDATA[7:0], AVS_BYTEENABLE[0]);
      end
      if (reg_hit(AVS_ADDRESS, {1'b0, `BAC_OFF_A_EXT})) begin
        comp_a_extended_page_d = lane(comp_a_extended_page_q, AVS_WRITEDATA[7:0],
                                      AVS_BYTEENABLE[0]);
      end
      if (reg_hit(AVS_ADDRESS, `BAC_OFF_A_CMP)) begin
        comp_a_compare_value_d[7:0] = lane(comp_a_compare_value_q[7:0],
                                           AVS_WRITEDATA[7:0], AVS_BYTEENABLE[0]);
        comp_a_compare_value_d[15:8] = lane(comp_a_compare_value_q[15:8],
                                            AVS_WRITEDATA[15:8], AVS_BYTEENABLE[1]);
      end
      if (reg_hit(AVS_ADDRESS, `BAC_OFF_B_EXT)) begin
        comp_b_extended_page_d = lane(comp_b_extended_page_q, AVS_WRITEDATA[7:0],
                                      AVS_BYTEENABLE[0]);
      end
      if (reg_hit(AVS_ADDRESS, `BAC_OFF_B_CMP)) begin
        comp_b_compare_value_d[7:0] = lane(comp_b_compare_value_q[7:0],
                                           AVS_WRITEDATA[7:0], AVS_BYTEENABLE[0]);
        comp_b_compare_value_d[15:8] = lane(comp_b_compare_value_q[15:8],
                                            AVS_WRITEDATA[15:8], AVS_BYTEENABLE[1]);
      end
    end
  end

  // Register file, one flop bank per register
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      debug_control_one_q <= `BAC_RST_BYTE;
    end else begin
      debug_control_one_q <= debug_control_one_d;
    end
  end

  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      debug_control_two_q <= `BAC_RST_BYTE;
    end else begin
      debug_control_two_q <= debug_control_two_d;
    end
  end

  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      mask_ctrl_q <= `BAC_RST_BYTE;
    end else begin
      mask_ctrl_q <= mask_ctrl_d;
    end
  end

  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      comp_a_extended_page_q <= `BAC_RST_BYTE;
    end else begin
      comp_a_extended_page_q <= comp_a_extended_page_d;
    end
  end

  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      comp_a_compare_value_q <= `BAC_RST_WORD;
    end else begin
      comp_a_compare_value_q <= comp_a_compare_value_d;
    end
  end

  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      comp_b_extended_page_q <= `BAC_RST_BYTE;
    end else begin
      comp_b_extended_page_q <= comp_b_extended_page_d;
    end
  end

  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      comp_b_compare_value_q <= `BAC_RST_WORD;
    end else begin
      comp_b_compare_value_q <= comp_b_compare_value_d;
    end
  end

  bac_match u_cmp_a (
    .bkp_mode(bkp_on),
    .dbg_mode(dbg_on),
    .data_cmp(1'b0),
    .high_mask(mask_ctrl_q[`BAC_BIT_A_HMASK]),
    .low_mask(mask_ctrl_q[`BAC_BIT_A_LMASK]),
    .ext_reg(comp_a_extended_page_q),
    .cmp_reg(comp_a_compare_value_q),
    .addr(CORE_ADDRESS_BUS),
    .xaddr(EXTENDED_ADDRESS_BUS),
    .flash_access(FLASH_ACCESS),
    .data(CORE_DATA_BUS),
    .hit(hit_a)
  );

  // Full mode turns comparator B onto the data bus
  bac_match u_cmp_b (
    .bkp_mode(bkp_on),
    .dbg_mode(dbg_on),
    .data_cmp(full_mode),
    .high_mask(mask_ctrl_q[`BAC_BIT_B_HMASK]),
    .low_mask(mask_ctrl_q[`BAC_BIT_B_LMASK]),
    .ext_reg(comp_b_extended_page_q),
    .cmp_reg(comp_b_compare_value_q),
    .addr(CORE_ADDRESS_BUS),
    .xaddr(EXTENDED_ADDRESS_BUS),
    .flash_access(FLASH_ACCESS),
    .data(CORE_DATA_BUS),
    .hit(hit_b)
  );

  // Registered results, one cycle behind the core buses
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      MATCH_A <= 1'b0;
      MATCH_B <= 1'b0;
      BREAKPOINT_MODE <= 1'b0;
      TRACE_DEBUG_MODE <= 1'b0;
    end else begin
      MATCH_A <= hit_a;
      MATCH_B <= hit_b;
      BREAKPOINT_MODE <= bkp_on;
      TRACE_DEBUG_MODE <= dbg_on;
    end
  end

endmodule // bac_top

`default_nettype wire

// ### sim/bac_properties.sv
// Port assertions for the breakpoint comparators
`timescale 1ns/1ns
`default_nettype none
module bac_props (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Register bus
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  // Security, modes, results
  input wire logic SECURE_STATE,
  input wire logic MATCH_A,
  input wire logic MATCH_B,
  input wire logic BREAKPOINT_MODE,
  input wire logic TRACE_DEBUG_MODE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  one_mode_a: assert property (!(BREAKPOINT_MODE && TRACE_DEBUG_MODE))
    else $error("both modes on");
  // Two synchroniser flops plus the mode register
  secure_lock_a: assert property (SECURE_STATE [*3] |=> !TRACE_DEBUG_MODE)
    else $error("debug while secure");
  bkp_by_write_a: assert property ($changed(BREAKPOINT_MODE) |->
    $past(AVS_WRITE) || $past(AVS_WRITE, 2)) else $error("mode moved alone");
  idle_quiet_a: assert property (!BREAKPOINT_MODE && !TRACE_DEBUG_MODE &&
    $past(!BREAKPOINT_MODE && !TRACE_DEBUG_MODE) |-> !MATCH_A && !MATCH_B) else $error("idle hit");
  wait_answer_a: assert property ($rose(AVS_READ || AVS_WRITE) |=> !AVS_WAITREQUEST)
    else $error("late answer");
  wait_single_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("long answer");
  wait_cause_a: assert property (!AVS_WAITREQUEST |-> AVS_READ || AVS_WRITE)
    else $error("answer unasked");
  wait_idle_a: assert property (!AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST)
    else $error("answer when idle");
endmodule // bac_props
bind bac_top bac_props chk (.CORE_CLK(CORE_CLK), .RST(RST), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .SECURE_STATE(SECURE_STATE),
  .MATCH_A(MATCH_A), .MATCH_B(MATCH_B), .BREAKPOINT_MODE(BREAKPOINT_MODE),
  .TRACE_DEBUG_MODE(TRACE_DEBUG_MODE));
`default_nettype wire

// ### sim/bac_cpu.sv
// Core bus model: address, page bits, flash flag, data
`timescale 1ns/1ns
`default_nettype none
module bac_cpu (
  // Clock
  input wire logic clk,
  // Core buses
  output logic [15:0] ab,
  output logic [21:14] extended_address_bus,
  output logic fl,
  output logic [15:0] db
);
  initial begin
    ab = 16'h0;
    extended_address_bus = 8'h0;
    fl = 1'b0;
    db = 16'h0;
  end
  // One bus cycle per call, launched just after an edge
  task automatic put(input logic [15:0] a, input logic [7:0] x, input logic f,
      input logic [15:0] d);
    @(posedge clk);
    ab <= a;
    extended_address_bus <= x;
    fl <= f;
    db <= d;
  endtask
endmodule // bac_cpu
`default_nettype wire

// ### sim/test_breakpoint_address_comparators.sv
// Self-checking bench for the breakpoint comparators
`timescale 1ns/1ns
`default_nettype none
module test_breakpoint_address_comparators;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, sec = 1'b0;
  logic [4:0] adr = 5'h0;
  logic [31:0] wd = 32'h0, rdata;
  wire [31:0] rdw;
  wire wrq, ma, mb, bm, tm, fl;
  wire [15:0] ab, db;
  wire [21:14] extended_address_bus;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  always #25 clk = ~clk;
  bac_top dut (.CORE_CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdw), .AVS_WAITREQUEST(wrq),
    .CORE_ADDRESS_BUS(ab), .EXTENDED_ADDRESS_BUS(extended_address_bus), .FLASH_ACCESS(fl), .CORE_DATA_BUS(db),
    .SECURE_STATE(sec), .MATCH_A(ma), .MATCH_B(mb), .BREAKPOINT_MODE(bm),
    .TRACE_DEBUG_MODE(tm));
  bac_cpu cpu (.clk(clk), .ab(ab), .extended_address_bus(extended_address_bus), .fl(fl), .db(db));
  task chk(input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wrq !== 1'b0 && n < 20);
    rdata = rdw;
    wr <= 1'b0;
    rd <= 1'b0;
    chk(0, wrq);
  endtask
  // Match outputs are registered: look one edge after the bus cycle
  task automatic probe(input logic [15:0] a, input logic [7:0] x, input logic f,
      input logic [15:0] d, input logic ea, input logic eb);
    cpu.put(a, x, f, d);
    @(posedge clk);
    #1 chk(ea, ma);
    chk(eb, mb);
  endtask
  task t_regs;
    bus(1'b0, 5'h10, 32'h0);
    chk(0, rdata);
    bus(1'b0, 5'h1C, 32'h0);
    chk(0, rdata);
    bus(1'b1, 5'h10, 32'h1234);
    bus(1'b0, 5'h10, 32'h0);
    chk(32'h1234, rdata);
  endtask
  task t_modes;
    bus(1'b1, 5'h0, 32'h80);
    @(posedge clk);
    #1 chk(1, tm);
    @(posedge clk);
    sec <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(0, tm);
    @(posedge clk);
    sec <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk(1, tm);
    bus(1'b1, 5'h4, 32'h80);
    @(posedge clk);
    #1 chk(1, bm);
    chk(0, tm);
    bus(1'b0, 5'h1C, 32'h0);
    chk(32'h6, rdata);
  endtask
  task t_addr;
    bus(1'b1, 5'hC, 32'h5);
    probe(16'h1234, 8'h3F, 1'b0, 16'h0, 1, 0);
    probe(16'h1235, 8'h0, 1'b0, 16'h0, 0, 0);
    probe(16'hD234, 8'hC5, 1'b1, 16'h0, 1, 0);
    probe(16'h1234, 8'h6, 1'b1, 16'h0, 0, 0);
    bus(1'b1, 5'h8, 32'h80);
    probe(16'h12FF, 8'h0, 1'b0, 16'h0, 0, 0);
    bus(1'b1, 5'h8, 32'h40);
    probe(16'h12FF, 8'h0, 1'b0, 16'h0, 1, 0);
    bus(1'b1, 5'h8, 32'hC0);
    probe(16'hFFFF, 8'h5, 1'b1, 16'h0, 1, 0);
    probe(16'hFFFF, 8'h6, 1'b1, 16'h0, 0, 0);
  endtask
  task t_page;
    bus(1'b1, 5'h8, 32'h0);
    bus(1'b1, 5'h4, 32'h0);
    bus(1'b1, 5'hC, 32'h45);
    probe(16'hD234, 8'h14, 1'b0, 16'h0, 1, 0);
    probe(16'hD234, 8'h15, 1'b0, 16'h0, 0, 0);
    bus(1'b1, 5'hC, 32'hC5);
    probe(16'hD234, 8'h14, 1'b0, 16'h0, 1, 0);
    bus(1'b1, 5'hC, 32'h85);
    probe(16'h1234, 8'hFF, 1'b0, 16'h0, 1, 0);
    probe(16'hD234, 8'h14, 1'b0, 16'h0, 0, 0);
  endtask
  task t_data;
    bus(1'b1, 5'h18, 32'hABCD);
    bus(1'b1, 5'h14, 32'h3F);
    bus(1'b1, 5'h4, 32'hC0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 5'h8, i << 4);
      probe(16'h1234, 8'h0, 1'b0, 16'hAB00, 1, i[0]);
      probe(16'h1234, 8'h0, 1'b0, 16'h00CD, 1, i[1]);
      probe(16'h1234, 8'h0, 1'b0, 16'hABCD, 1, 1);
      probe(16'h1234, 8'h0, 1'b1, 16'hABCD, 0, 1);
    end
  endtask
  // Mid-run reset: wait request, match and mode outputs return to their idle levels
  task t_reset;
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    #1 chk(1, wrq);
    chk(0, {mb, ma, bm, tm});
    @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, 5'h18, 32'h0);
    chk(0, rdata);
  endtask
  task summarize;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      summarize;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_modes;
    t_addr;
    t_page;
    t_data;
    t_reset;
    summarize;
  end
endmodule // test_breakpoint_address_comparators
`default_nettype wire
